// ### design/timer_event_pkg.sv
// shared constants and types of the timer event and interrupt slice
package timer_event_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned NUM_CH = 2;

  // register offsets
  localparam logic [4:0] OFS_CONTROL       = 5'h00;
  localparam logic [4:0] OFS_DEBUG_CONTROL = 5'h08;
  localparam logic [4:0] OFS_EVENT_CONTROL = 5'h0A;
  localparam logic [4:0] OFS_INT_EN_CLEAR  = 5'h0C;
  localparam logic [4:0] OFS_INT_EN_SET    = 5'h0D;
  localparam logic [4:0] OFS_INT_FLAGS     = 5'h0E;

  // control register fields
  localparam int unsigned CTRL_SOFT_RESET_BIT = 0;
  localparam int unsigned CTRL_ENABLE_BIT     = 1;
  // debug control field
  localparam int unsigned DBG_RUN_BIT = 0;

  // event control fields
  localparam int unsigned EVC_MATCH_EO_LSB = 12;
  localparam int unsigned EVC_WRAP_EO_BIT  = 8;
  localparam int unsigned EVC_IN_EN_BIT    = 5;
  localparam int unsigned EVC_IN_INV_BIT   = 4;
  localparam int unsigned EVC_ACT_LSB      = 0;
  localparam int unsigned EVC_ACT_W        = 3;
  // writable bits of event control
  localparam logic [15:0] EVC_MASK = 16'h3137;

  // interrupt enable and flag layout
  localparam int unsigned IRQ_WRAP_BIT     = 0;
  localparam int unsigned IRQ_ERROR_BIT    = 1;
  localparam int unsigned IRQ_SYNC_BIT     = 3;
  localparam int unsigned IRQ_MATCH_LSB    = 4;
  localparam logic [7:0]  IRQ_MASK         = 8'h3B;

  // reset values
  localparam logic [15:0] EVC_RESET  = 16'h0000;
  localparam logic [7:0]  INT_RESET  = 8'h00;
  localparam logic [15:0] READ_ZERO  = 16'h0000;

  // event action encodings
  typedef enum logic [2:0] {
    ACT_OFF       = 3'h0,
    ACT_RETRIGGER = 3'h1,
    ACT_COUNT     = 3'h2,
    ACT_START     = 3'h3,
    ACT_RSVD4     = 3'h4,
    ACT_PPW       = 3'h5,
    ACT_PWP       = 3'h6,
    ACT_RSVD7     = 3'h7
  } event_action_sel_t;

  // strobes coming from the counter core, all one-cycle pulses
  typedef struct packed {
    logic       counter_wrap;
    logic [1:0] match;
    logic [1:0] capture;
    logic [1:0] capture_mode;
    logic [1:0] compare_read;
    logic       sync_ready;
  } core_strobes_t;

  // actions requested of the counter core, one-cycle pulses
  typedef struct packed {
    logic retrigger;
    logic count;
    logic start;
    logic period_then_pulse_capture;
    logic pulse_then_period_capture;
  } event_actions_t;

endpackage

// ### design/pin_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_level
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic agreed;

  // stage one feeds only stage two
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      agreed <= 1'b0;
    end else if (i_ce) begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        agreed <= stage3;
      end
    end
  end

  assign o_level = agreed;

endmodule

// ### design/flag_bank.sv
// sticky flags: some set at once, some on the next counter tick, write one to clear
`timescale 1ns/1ps
module flag_bank (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_soft_reset,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_set_now,
  input  wire logic [7:0] i_set_tick,
  input  wire logic [7:0] i_clear,
  output logic [7:0]      o_flags,
  output logic [7:0]      o_pending
);

  logic [7:0] flags;
  logic [7:0] pending;
  logic [7:0] next_flags;
  logic [7:0] next_pending;

  // an event seen this cycle waits for a later tick; set beats clear
  assign next_pending = i_tick ? i_set_tick : (pending | i_set_tick);
  assign next_flags   = (flags & ~i_clear) | i_set_now
                      | (i_tick ? pending : timer_event_pkg::INT_RESET);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags   <= timer_event_pkg::INT_RESET;
      pending <= timer_event_pkg::INT_RESET;
    end else if (i_ce) begin
      if (i_soft_reset) begin
        flags   <= timer_event_pkg::INT_RESET;
        pending <= timer_event_pkg::INT_RESET;
      end else begin
        flags   <= next_flags & timer_event_pkg::IRQ_MASK;
        pending <= next_pending & timer_event_pkg::IRQ_MASK;
      end
    end
  end

  assign o_flags   = flags;
  assign o_pending = pending;

endmodule

// ### design/timer_event_ctrl.sv
// event routing, debug run control and interrupt registers of a timer
//
// Function
// [RL1] Software reset of the timer leaves the debug run bit untouched.
// [RL2] Debug run clear halts the timer during debug halt; set keeps it running.
// [RL3] Software should not change debug run while the timer is enabled.
// [RL4] Channel match or capture gives an output event only when enabled.
// [RL5] Counter wrap gives an output event only when its enable is set.
// [RL6] Incoming events act only while the event input enable is one.
// [RL7] Event input invert bit flips the incoming source before use.
// [RL8] Action codes: off, retrigger, count, start; four and seven reserved.
// [RL9] Code five captures period then pulse; code six swaps destinations.
// [RL10] Event control writes need write access and a disabled timer.
// [RL11] Writing one to enable-clear clears that enable; zero does nothing.
// [RL12] Writing one to enable-set sets that enable; zero does nothing.
// [RL13] Enable-set and enable-clear read back one shared enable set.
// [RL14] Enables and flags share layout: match 5,4, sync 3, error 1, wrap 0.
// [RL15] Flag register sits at 0x0E and resets to zero.
// [RL16] Match flag sets on the next counter tick; enabled one requests irq.
// [RL17] Flags clear on write one; capture mode compare read clears match.
// [RL18] Capture while match flag still set raises the error flag.
// [RL19] Wrap flag sets on the next counter tick; enabled one requests irq.
// [RL20] Writing one to sync ready in enable-set sets that enable.
// [RL21] Interrupt output is high while any enabled flag is set.
`timescale 1ns/1ps
module timer_event_ctrl (
  input  wire logic                           i_core_clk,
  input  wire logic                           i_rstn,
  input  wire logic                           i_ce,
  // register port
  input  wire logic [4:0]                     i_addr,
  input  wire logic [15:0]                    i_wdata,
  input  wire logic                           i_write,
  input  wire logic                           i_read,
  output logic [15:0]                         o_rdata,
  input  wire logic                           i_write_protect_ctrl,
  // system debug halt, from outside the clock domain
  input  wire logic                           i_debug_halt,
  // counter core side
  input  wire logic                           i_counter_clock,
  input  wire timer_event_pkg::core_strobes_t i_core,
  output logic                                o_timer_enabled,
  output logic                                o_timer_run,
  output logic                                o_soft_reset,
  output timer_event_pkg::event_actions_t     o_actions,
  // event routing network side
  input  wire logic                           i_event_in,
  output logic [1:0]                          o_channel_match_event,
  output logic                                o_wrap_event,
  // interrupt request
  output logic                                o_irq
);


  // register state

  logic        timer_enable;
  logic        run_while_halted;
  logic [15:0] event_control;
  logic [7:0]  int_enable;
  logic        soft_reset;
  logic [15:0] rdata;

  // event path state
  logic        event_prev;
  logic        halt_level;
  logic        event_level;
  logic [1:0]  match_event_out;
  logic        wrap_event_out;
  timer_event_pkg::event_actions_t actions;

  // flag bank wiring
  logic [7:0]  flags;
  logic [7:0]  flags_pending;
  logic [7:0]  flag_set_now;
  logic [7:0]  flag_set_tick;
  logic [7:0]  flag_clear;


  // address decode

  wire sel_control  = (i_addr == timer_event_pkg::OFS_CONTROL);
  wire sel_debug    = (i_addr == timer_event_pkg::OFS_DEBUG_CONTROL);
  wire sel_event_control   = (i_addr == timer_event_pkg::OFS_EVENT_CONTROL);
  wire sel_en_clear = (i_addr == timer_event_pkg::OFS_INT_EN_CLEAR);
  wire sel_en_set   = (i_addr == timer_event_pkg::OFS_INT_EN_SET);
  wire sel_flags    = (i_addr == timer_event_pkg::OFS_INT_FLAGS); // RL15

  // protected writes are dropped while the write protect line is high
  wire wr_open      = i_write & ~i_write_protect_ctrl;
  wire wr_control   = wr_open & sel_control;
  wire wr_debug     = wr_open & sel_debug;
  wire wr_event_control    = wr_open & sel_event_control & ~timer_enable; // RL10
  wire wr_en_clear  = wr_open & sel_en_clear;
  wire wr_en_set    = wr_open & sel_en_set;
  wire wr_flags     = i_write & sel_flags;

  // software reset wins over every other bit of the same write
  wire swrst_req    = wr_control
                    & i_wdata[timer_event_pkg::CTRL_SOFT_RESET_BIT];
  wire enable_wdata = i_wdata[timer_event_pkg::CTRL_ENABLE_BIT];


  // event control fields

  wire [1:0] match_eo_en = event_control[timer_event_pkg::EVC_MATCH_EO_LSB
                                         +: timer_event_pkg::NUM_CH];
  wire wrap_eo_en   = event_control[timer_event_pkg::EVC_WRAP_EO_BIT];
  wire ev_in_en     = event_control[timer_event_pkg::EVC_IN_EN_BIT];
  wire ev_in_inv    = event_control[timer_event_pkg::EVC_IN_INV_BIT];
  timer_event_pkg::event_action_sel_t event_action_sel;
  assign event_action_sel = timer_event_pkg::event_action_sel_t'(
    event_control[timer_event_pkg::EVC_ACT_LSB +: timer_event_pkg::EVC_ACT_W]);


  // control register: enable and self-clearing software reset

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer_enable <= 1'b0;
      soft_reset   <= 1'b0;
    end else if (i_ce) begin
      soft_reset <= swrst_req;
      if (swrst_req || soft_reset) begin
        timer_enable <= 1'b0;
      end else if (wr_control) begin
        timer_enable <= enable_wdata;
      end
    end
  end

  // debug control survives a software reset; only the hard reset clears it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_while_halted <= 1'b0;
    end else if (i_ce && wr_debug) begin
      run_while_halted <= i_wdata[timer_event_pkg::DBG_RUN_BIT]; // RL1
    end
  end

  // event control holds only documented bits, changed while disabled
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      event_control <= timer_event_pkg::EVC_RESET;
    end else if (i_ce) begin
      if (soft_reset) begin
        event_control <= timer_event_pkg::EVC_RESET;
      end else if (wr_event_control) begin
        event_control <= i_wdata & timer_event_pkg::EVC_MASK; // RL10
      end
    end
  end


  // interrupt enables: one shared set behind the set and clear views

  wire [7:0] en_wbyte = i_wdata[7:0] & timer_event_pkg::IRQ_MASK;
  wire [7:0] en_clear = wr_en_clear ? en_wbyte : timer_event_pkg::INT_RESET;
  wire [7:0] en_set   = wr_en_set ? en_wbyte : timer_event_pkg::INT_RESET;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_enable <= timer_event_pkg::INT_RESET;
    end else if (i_ce) begin
      if (soft_reset) begin
        int_enable <= timer_event_pkg::INT_RESET;
      end else begin
        // RL11 RL12 RL13 RL20
        int_enable <= (int_enable & ~en_clear) | en_set;
      end
    end
  end


  // debug halt and incoming event come from outside this clock

  pin_sync u_halt_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_ce       (i_ce),
    .i_async    (i_debug_halt),
    .o_level    (halt_level)
  );

  pin_sync u_event_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_ce       (i_ce),
    .i_async    (i_event_in),
    .o_level    (event_level)
  );

  // timer runs when enabled unless halted by debug without run permission
  wire debug_stop  = halt_level & ~run_while_halted; // RL2
  wire run_now     = timer_enable & ~debug_stop; // RL2

  // source after optional inversion, then its rising edge
  wire event_src   = event_level ^ ev_in_inv; // RL7
  wire event_edge  = event_src & ~event_prev;
  wire event_fire  = event_edge & ev_in_en & run_now; // RL6

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      event_prev <= 1'b0;
    end else if (i_ce) begin
      event_prev <= event_src;
    end
  end


  // event action decode, reserved codes do nothing

  wire act_retrigger = event_fire
                     & (event_action_sel == timer_event_pkg::ACT_RETRIGGER);
  wire act_count     = event_fire
                     & (event_action_sel == timer_event_pkg::ACT_COUNT);
  wire act_start     = event_fire
                     & (event_action_sel == timer_event_pkg::ACT_START);
  wire act_ppw       = event_fire
                     & (event_action_sel == timer_event_pkg::ACT_PPW);
  wire act_pwp       = event_fire
                     & (event_action_sel == timer_event_pkg::ACT_PWP);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      actions <= '0;
    end else if (i_ce) begin
      actions.retrigger                 <= act_retrigger; // RL8
      actions.count                     <= act_count; // RL8
      actions.start                     <= act_start; // RL8
      actions.period_then_pulse_capture <= act_ppw; // RL9
      actions.pulse_then_period_capture <= act_pwp; // RL9
    end
  end


  // outgoing events to the routing network

  wire [1:0] ch_hit = i_core.match | i_core.capture;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      match_event_out <= 2'h0;
      wrap_event_out  <= 1'b0;
    end else if (i_ce) begin
      match_event_out <= ch_hit & match_eo_en; // RL4
      wrap_event_out  <= i_core.counter_wrap & wrap_eo_en; // RL5
    end
  end


  // flag sources

  // a capture lands on a channel whose match flag is still standing
  wire [1:0] match_busy  = flags[timer_event_pkg::IRQ_MATCH_LSB +: 2]
                         | flags_pending[timer_event_pkg::IRQ_MATCH_LSB +: 2];
  wire       capture_err = |(i_core.capture & match_busy); // RL18

  // compare reads in capture mode clear the channel match flag
  wire [1:0] auto_clear  = i_core.compare_read & i_core.capture_mode; // RL17

  assign flag_set_tick = {2'h0, ch_hit, 1'b0, 1'b0, 1'b0,
                          i_core.counter_wrap}; // RL16 RL19
  assign flag_set_now  = {4'h0, i_core.sync_ready, 1'b0, capture_err, 1'b0};
  assign flag_clear    = (wr_flags ? i_wdata[7:0] : timer_event_pkg::INT_RESET)
                       | {2'h0, auto_clear, 4'h0}; // RL17

  flag_bank u_flags (
    .i_core_clk   (i_core_clk),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_soft_reset (soft_reset),
    .i_tick       (i_counter_clock),
    .i_set_now    (flag_set_now),
    .i_set_tick   (flag_set_tick),
    .i_clear      (flag_clear),
    .o_flags      (flags),
    .o_pending    (flags_pending)
  );


  // read data, one cycle after the strobe; unmapped reads give zero

  wire [15:0] rd_control = {14'h0000, timer_enable, 1'b0};
  wire [15:0] rd_debug   = {15'h0000, run_while_halted};
  wire [15:0] rd_enable  = {8'h00, int_enable}; // RL13 RL14
  wire [15:0] rd_flags   = {8'h00, flags}; // RL14
  wire [15:0] rd_mux     = sel_control  ? rd_control    :
                           sel_debug    ? rd_debug      :
                           sel_event_control   ? event_control :
                           sel_en_clear ? rd_enable     :
                           sel_en_set   ? rd_enable     :
                           sel_flags    ? rd_flags      :
                           timer_event_pkg::READ_ZERO;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata <= timer_event_pkg::READ_ZERO;
    end else if (i_ce) begin
      rdata <= i_read ? rd_mux : timer_event_pkg::READ_ZERO;
    end
  end


  // outputs

  assign o_rdata               = rdata;
  assign o_timer_enabled       = timer_enable;
  assign o_timer_run           = run_now; // RL2
  assign o_soft_reset          = soft_reset;
  assign o_actions             = actions;
  assign o_channel_match_event = match_event_out;
  assign o_wrap_event          = wrap_event_out;
  assign o_irq                 = |(flags & int_enable); // RL21 RL16 RL19

endmodule

// ### dv/timer_event_chk.sv
// port assertions for the timer event and interrupt slice
`timescale 1ns/1ps
module timer_event_chk (
  input wire logic                            i_core_clk,
  input wire logic                            i_rstn,
  input wire logic [4:0]                      i_addr,
  input wire logic [15:0]                     i_wdata,
  input wire logic                            i_write,
  input wire logic                            i_read,
  input wire logic [15:0]                     o_rdata,
  input wire logic                            i_write_protect_ctrl,
  input wire logic                            i_counter_clock,
  input wire timer_event_pkg::core_strobes_t  i_core,
  input wire logic                            o_timer_enabled,
  input wire logic                            o_timer_run,
  input wire logic                            o_soft_reset,
  input wire timer_event_pkg::event_actions_t o_actions,
  input wire logic [1:0]                      o_channel_match_event,
  input wire logic                            o_wrap_event,
  input wire logic                            o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  // read data stand only in the slot after a read strobe
  property p_rdata_idle;
    !$past(i_read) |-> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  // an output event needs a wrap strobe one cycle earlier
  property p_wrap_event;
    o_wrap_event |-> $past(i_core.counter_wrap);
  endproperty
  a_wrap_event: assert property (p_wrap_event)
    else $error("wrap event without wrap");
  // a channel event needs a match or capture on that channel
  property p_match_event;
    (o_channel_match_event & ~$past(i_core.match | i_core.capture)) == 2'b00;
  endproperty
  a_match_event: assert property (p_match_event)
    else $error("channel event without cause");
  // soft reset is a single pulse caused by a control write
  property p_soft_cause;
    o_soft_reset |-> $past(i_write && i_addr == 5'h00 && i_wdata[0]) ##1
      !o_soft_reset;
  endproperty
  a_soft_cause: assert property (p_soft_cause)
    else $error("soft reset pulse wrong");
  // soft reset leaves the timer disabled with no request
  property p_soft_clear;
    o_soft_reset |=> !o_timer_enabled && !o_irq;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft reset left state");
  // the timer only runs while enabled
  property p_run_enabled;
    o_timer_run |-> o_timer_enabled;
  endproperty
  a_run_enabled: assert property (p_run_enabled)
    else $error("run while disabled");
  // at most one action is requested per event
  property p_actions_onehot;
    $onehot0(o_actions);
  endproperty
  a_actions_onehot: assert property (p_actions_onehot)
    else $error("several actions at once");
  // clearing every flag with nothing setting drops the request
  property p_flag_clear;
    i_write && i_addr == 5'h0E && i_wdata[7:0] == 8'hFF && !i_counter_clock
      && i_core == '0 |=> !o_irq;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("irq after flag clear");
  // clearing every enable drops the request
  property p_en_clear;
    i_write && i_addr == 5'h0C && i_wdata[7:0] == 8'h3B
      && !i_write_protect_ctrl |=> !o_irq;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("irq after enable clear");
endmodule

bind timer_event_ctrl timer_event_chk chk_u (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
  .o_rdata(o_rdata), .i_write_protect_ctrl(i_write_protect_ctrl),
  .i_counter_clock(i_counter_clock), .i_core(i_core),
  .o_timer_enabled(o_timer_enabled), .o_timer_run(o_timer_run),
  .o_soft_reset(o_soft_reset), .o_actions(o_actions),
  .o_channel_match_event(o_channel_match_event),
  .o_wrap_event(o_wrap_event), .o_irq(o_irq)
);

// ### dv/event_net_model.sv
// event routing network model: launches an event level from its own flop
`timescale 1ns/1ps
module event_net_model (
  input  wire logic i_core_clk,
  input  wire logic i_fire,
  output logic      o_event
);
  // level idles low and changes only after a clock edge
  always_ff @(posedge i_core_clk) begin
    o_event <= i_fire;
  end
endmodule

// ### dv/timer_event_ctrl_tb_top.sv
// self-checking bench for the timer event and interrupt slice
`timescale 1ns/1ps
module timer_event_ctrl_tb_top;
  logic                            i_core_clk = 1'b0;
  logic                            i_rstn = 1'b0;
  logic [4:0]                      i_addr = 5'h00;
  logic [15:0]                     i_wdata = 16'h0000;
  logic                            i_write = 1'b0;
  logic                            i_read = 1'b0;
  logic                            i_write_protect_ctrl = 1'b0;
  logic                            i_debug_halt = 1'b0;
  logic                            i_counter_clock = 1'b0;
  timer_event_pkg::core_strobes_t  i_core = '0;
  logic                            ev_fire = 1'b0;
  logic                            i_event_in;
  logic [15:0]                     o_rdata;
  logic                            o_timer_enabled;
  logic                            o_timer_run;
  logic                            o_soft_reset;
  timer_event_pkg::event_actions_t o_actions;
  logic [1:0]                      o_channel_match_event;
  logic                            o_wrap_event;
  logic                            o_irq;
  logic [2:0]                      ev_seen;
  logic [4:0]                      act_hi;
  logic [4:0]                      act_lo;
  int                              n_errors = 0;
  int                              tests_run = 0;
  int                              cycles = 0;

  timer_event_ctrl dut_u (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .o_rdata(o_rdata),
    .i_write_protect_ctrl(i_write_protect_ctrl),
    .i_debug_halt(i_debug_halt), .i_counter_clock(i_counter_clock),
    .i_core(i_core), .o_timer_enabled(o_timer_enabled),
    .o_timer_run(o_timer_run), .o_soft_reset(o_soft_reset),
    .o_actions(o_actions), .i_event_in(i_event_in),
    .o_channel_match_event(o_channel_match_event),
    .o_wrap_event(o_wrap_event), .o_irq(o_irq)
  );
  event_net_model net_u (
    .i_core_clk(i_core_clk), .i_fire(ev_fire), .o_event(i_event_in)
  );

  // 200 MHz clock and a hang limit
  always #2.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // register bus cycles
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge i_core_clk);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_read <= 1'b0;
    #1;
    chk(nm, e, o_rdata);
  endtask
  // one-cycle core strobe, then the events it gave
  task automatic strobe(input timer_event_pkg::core_strobes_t s);
    @(posedge i_core_clk);
    i_core <= s;
    @(posedge i_core_clk);
    i_core <= '0;
    #1;
    ev_seen = {o_wrap_event, o_channel_match_event};
  endtask
  task automatic tick();
    @(posedge i_core_clk);
    i_counter_clock <= 1'b1;
    @(posedge i_core_clk);
    i_counter_clock <= 1'b0;
  endtask
  // event high then low, actions gathered in each phase
  task automatic evt();
    act_hi = '0;
    act_lo = '0;
    @(posedge i_core_clk);
    ev_fire <= 1'b1;
    repeat (10) @(posedge i_core_clk) act_hi = act_hi | o_actions;
    ev_fire <= 1'b0;
    repeat (10) @(posedge i_core_clk) act_lo = act_lo | o_actions;
  endtask

  task automatic t_regs();
    rd(5'h0E, 16'h0000, "flags reset");
    rd(5'h0A, 16'h0000, "event_control reset");
    rd(5'h1F, 16'h0000, "unmapped");
    wr(5'h0D, 16'h003B);
    rd(5'h0C, 16'h003B, "enables shared");
    wr(5'h0C, 16'h0011);
    rd(5'h0D, 16'h002A, "enable clear");
    wr(5'h0C, 16'h003B);
    rd(5'h0D, 16'h0000, "enables cleared");
    @(posedge i_core_clk);
    i_write_protect_ctrl <= 1'b1;
    wr(5'h0A, 16'h0001);
    i_write_protect_ctrl <= 1'b0;
    rd(5'h0A, 16'h0000, "protected event_control");
  endtask
  task automatic t_wrap();
    wr(5'h0D, 16'h0001);
    strobe(10'h200);
    chk("wrap event off", 16'h0000, {13'h0000, ev_seen});
    tick();
    rd(5'h0E, 16'h0001, "wrap flag");
    chk("irq wrap", 16'h0001, {15'h0000, o_irq});
    wr(5'h0E, 16'h0000);
    rd(5'h0E, 16'h0001, "flag write zero");
    wr(5'h0E, 16'h00FF);
    rd(5'h0E, 16'h0000, "flag write one");
    wr(5'h0A, 16'h0100);
    strobe(10'h200);
    chk("wrap event on", 16'h0004, {13'h0000, ev_seen});
    tick();
    wr(5'h0E, 16'h00FF);
  endtask
  task automatic t_match();
    wr(5'h0A, 16'h1000);
    wr(5'h0D, 16'h0010);
    strobe(10'h080);
    chk("ch0 event", 16'h0001, {13'h0000, ev_seen});
    strobe(10'h100);
    chk("ch1 event off", 16'h0000, {13'h0000, ev_seen});
    tick();
    rd(5'h0E, 16'h0030, "match flags");
    chk("irq match", 16'h0001, {15'h0000, o_irq});
    strobe(10'h020);
    rd(5'h0E, 16'h0032, "capture error");
    strobe(10'h00B);
    rd(5'h0E, 16'h002A, "compare read");
    tick();
    wr(5'h0E, 16'h00FF);
    wr(5'h0C, 16'h003B);
  endtask
  task automatic t_actions();
    logic [4:0] exp [8] = '{5'h00, 5'h10, 5'h08, 5'h04,
                            5'h00, 5'h02, 5'h01, 5'h00};
    for (int c = 0; c < 8; c++) begin
      wr(5'h00, 16'h0000);
      wr(5'h0A, 16'h0020 | 16'(c));
      wr(5'h00, 16'h0002);
      evt();
      chk("action", {11'h000, exp[c]}, {11'h000, act_hi});
    end
    wr(5'h0A, 16'h0000);
    rd(5'h0A, 16'h0027, "event_control locked");
    wr(5'h00, 16'h0000);
    wr(5'h0A, 16'h0001);
    wr(5'h00, 16'h0002);
    evt();
    chk("input off", 16'h0000, {11'h000, act_hi | act_lo});
    wr(5'h00, 16'h0000);
    wr(5'h0A, 16'h0032);
    wr(5'h00, 16'h0002);
    evt();
    chk("inverted high", 16'h0000, {11'h000, act_hi});
    chk("inverted low", 16'h0008, {11'h000, act_lo});
  endtask
  task automatic t_debug();
    wr(5'h00, 16'h0000);
    wr(5'h08, 16'h0001);
    wr(5'h00, 16'h0003);
    rd(5'h08, 16'h0001, "run bit kept");
    rd(5'h0A, 16'h0000, "event_control soft reset");
    wr(5'h00, 16'h0002);
    @(posedge i_core_clk);
    i_debug_halt <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1;
    chk("run in halt", 16'h0001, {15'h0000, o_timer_run});
    wr(5'h00, 16'h0000);
    wr(5'h08, 16'h0000);
    wr(5'h00, 16'h0002);
    #1;
    chk("halted", 16'h0000, {15'h0000, o_timer_run});
  endtask

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_regs();
    t_wrap();
    t_match();
    t_actions();
    t_debug();
    stop_test();
  end
endmodule
